// ### rtl/disp_pkg.sv
// shared constants and types of the display command interpreter
package disp_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned RAM_AW = 10;

  // opcodes
  localparam logic [7:0] OP_COL_LO = 8'h00;
  localparam logic [7:0] OP_COL_HI = 8'h10;
  localparam logic [7:0] OP_MODE = 8'h20;
  localparam logic [7:0] OP_COL_WIN = 8'h21;
  localparam logic [7:0] OP_PAGE_WIN = 8'h22;
  localparam logic [7:0] OP_PAGE_SET = 8'hB0;
  localparam logic [7:0] OP_DISP_OFF = 8'hAE;
  localparam logic [7:0] OP_DISP_ON = 8'hAF;
  localparam logic [7:0] OP_CLK_SET = 8'hD5;
  localparam logic [7:0] OP_PRECHG = 8'hD9;
  localparam logic [7:0] OP_DESEL = 8'hDB;
  // two-byte commands handled elsewhere; parameter only skipped here
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_MUX = 8'hA8;
  localparam logic [7:0] OP_OFFSET = 8'hD3;
  localparam logic [7:0] OP_COM_CFG = 8'hDA;
  localparam logic [7:0] OP_GPIO = 8'hDC;
  localparam logic [7:0] OP_LOCK = 8'hFD;

  // field positions
  localparam int unsigned NIB_LO = 0;
  localparam int unsigned NIB_HI = 4;
  localparam int unsigned DESEL_LSB = 2;
  localparam int unsigned STAT_OFF_BIT = 6;

  // reset values
  localparam logic [3:0] RST_CLK_DIV = 4'h0;
  localparam logic [3:0] RST_OSC = 4'h7;
  localparam logic [3:0] RST_PH1 = 4'h2;
  localparam logic [3:0] RST_PH2 = 4'h2;
  localparam logic [3:0] RST_DESEL = 4'hD;
  localparam logic [7:0] RST_COL_START = 8'h00;
  localparam logic [7:0] RST_COL_END = 8'h7F;
  localparam logic [2:0] RST_PAGE_START = 3'h0;
  localparam logic [2:0] RST_PAGE_END = 3'h7;

  typedef enum logic [1:0] {
    MODE_HORIZ = 2'h0,
    MODE_VERT = 2'h1,
    MODE_PAGE = 2'h2,
    MODE_BAD = 2'h3
  } addr_mode_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_ARG1 = 2'h1,
    PH_ARG2 = 2'h3
  } cmd_phase_e;

  typedef struct packed {
    logic dc;
    logic rnw;
    logic [7:0] data;
  } host_req_s;

  localparam int unsigned REQ_W = $bits(host_req_s);

  typedef struct packed {
    logic [3:0] clk_div;
    logic [3:0] osc;
    logic [3:0] ph1;
    logic [3:0] ph2;
    logic [3:0] desel;
    logic disp_on;
  } timing_s;

  typedef struct packed {
    addr_mode_e mode;
    logic [7:0] col_start;
    logic [7:0] col_end;
    logic [2:0] page_start;
    logic [2:0] page_end;
    logic [7:0] col;
    logic [2:0] page;
  } addr_s;

endpackage

// ### rtl/req_fifo.sv
// request fifo between the host pins and the command interpreter
module req_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_s;

  fifo_state_s s_r;
  fifo_state_s s_nxt;
  logic push;
  logic pop;

  // no take while reset holds, else a byte offered then would be lost
  assign in_ready = rst_n && (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ### rtl/display_ram.sv
// display ram, 8 pages x 128 columns, registered read data
module display_ram (
  input wire logic clk,
  input wire logic we,
  input wire logic [disp_pkg::RAM_AW-1:0] addr,
  input wire logic [disp_pkg::DATA_W-1:0] wdata,
  output logic [disp_pkg::DATA_W-1:0] rdata
);

  logic [disp_pkg::DATA_W-1:0] mem [0:(1<<disp_pkg::RAM_AW)-1];

  // no reset: contents are undefined until written, as on a real panel ram
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ### rtl/disp_cmd_top.sv
// command interpreter, timing setup store and display ram pointer control
module disp_cmd_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_mode,
  input wire logic host_valid,
  output logic host_ready,
  input wire disp_pkg::host_req_s host_req,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output disp_pkg::timing_s timing,
  output disp_pkg::addr_s addr
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    disp_pkg::cmd_phase_e phase;
    logic [7:0] op;
    disp_pkg::timing_s tim;
    disp_pkg::addr_s adr;
    logic fetch_pend;
    logic [7:0] rd_latch;
    logic rd_valid;
    logic [7:0] rd_data;
  } top_state_s;

  logic rst_meta_r;
  logic rst_sync_r;
  top_state_s s_r;
  top_state_s s_nxt;
  disp_pkg::host_req_s q_req;
  logic q_valid;
  logic q_ready;
  logic ram_we;
  logic [disp_pkg::RAM_AW-1:0] ram_addr;
  logic [7:0] ram_rdata;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  req_fifo #(
    .WIDTH(disp_pkg::REQ_W),
    .DEPTH(disp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_sync_r),
    .in_valid(host_valid),
    .in_ready(host_ready),
    .in_data(host_req),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_req)
  );

  display_ram u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(q_req.data),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pointer step after one data access
  function automatic disp_pkg::addr_s step_ptr(input disp_pkg::addr_s a);
    disp_pkg::addr_s r;
    logic col_last;
    logic page_last;
    r = a;
    col_last = (a.col == a.col_end);
    page_last = (a.page == a.page_end);
    unique case (a.mode)
      disp_pkg::MODE_PAGE: begin
        r.col = col_last ? a.col_start : a.col + 8'h01;
      end
      disp_pkg::MODE_HORIZ: begin
        r.col = col_last ? a.col_start : a.col + 8'h01;
        if (col_last) begin
          r.page = page_last ? a.page_start : a.page + 3'h1;
        end
      end
      disp_pkg::MODE_VERT: begin
        r.page = page_last ? a.page_start : a.page + 3'h1;
        if (page_last) begin
          r.col = col_last ? a.col_start : a.col + 8'h01;
        end
      end
      default: begin
        r = a;
      end
    endcase
    return r;
  endfunction

  function automatic logic skips_param(input logic [7:0] op);
    return (op == disp_pkg::OP_CONTRAST) || (op == disp_pkg::OP_MUX) ||
           (op == disp_pkg::OP_OFFSET) || (op == disp_pkg::OP_COM_CFG) ||
           (op == disp_pkg::OP_GPIO) || (op == disp_pkg::OP_LOCK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // stall while a fetch or an unread answer is outstanding, so fifo fills
  assign q_ready = !s_r.fetch_pend && !s_r.rd_valid;
  assign ram_addr = {s_r.adr.page, s_r.adr.col[6:0]};
  assign rd_valid = s_r.rd_valid;
  assign rd_data = s_r.rd_data;
  assign timing = s_r.tim;
  assign addr = s_r.adr;

  always_comb begin
    logic is_read;
    logic [7:0] d;
    is_read = 1'b0;
    d = q_req.data;
    s_nxt = s_r;
    ram_we = 1'b0;
    is_read = q_req.rnw && !serial_mode;
    if (s_r.rd_valid && rd_ready) begin
      s_nxt.rd_valid = 1'b0;
    end
    if (s_r.fetch_pend) begin
      s_nxt.rd_latch = ram_rdata;
      s_nxt.fetch_pend = 1'b0;
    end
    if (q_valid && q_ready) begin
      if (q_req.dc) begin
        if (is_read) begin
          // answer holds the previous fetch; first one after positioning is stale
          s_nxt.rd_data = s_r.rd_latch;
          s_nxt.rd_valid = 1'b1;
          s_nxt.fetch_pend = 1'b1;
        end else begin
          ram_we = 1'b1;
        end
        s_nxt.adr = step_ptr(s_r.adr);
      end else if (is_read) begin
        s_nxt.rd_data = 8'h00;
        s_nxt.rd_data[disp_pkg::STAT_OFF_BIT] = !s_r.tim.disp_on;
        s_nxt.rd_valid = 1'b1;
      end else begin
        unique case (s_r.phase)
          disp_pkg::PH_IDLE: begin
            s_nxt.op = d;
            if (d[7:4] == disp_pkg::OP_COL_LO[7:4]) begin
              s_nxt.adr.col[3:0] = d[3:0];
            end else if (d[7:4] == disp_pkg::OP_COL_HI[7:4]) begin
              s_nxt.adr.col[7:4] = d[3:0];
            end else if (d[7:3] == disp_pkg::OP_PAGE_SET[7:3]) begin
              if (s_r.adr.mode == disp_pkg::MODE_PAGE) begin
                s_nxt.adr.page = d[2:0];
              end
            end else if (d == disp_pkg::OP_DISP_OFF) begin
              s_nxt.tim.disp_on = 1'b0;
            end else if (d == disp_pkg::OP_DISP_ON) begin
              s_nxt.tim.disp_on = 1'b1;
            end else if ((d == disp_pkg::OP_MODE) || (d == disp_pkg::OP_COL_WIN) ||
                         (d == disp_pkg::OP_PAGE_WIN) || (d == disp_pkg::OP_CLK_SET) ||
                         (d == disp_pkg::OP_PRECHG) || (d == disp_pkg::OP_DESEL) ||
                         skips_param(d)) begin
              s_nxt.phase = disp_pkg::PH_ARG1;
            end
          end
          disp_pkg::PH_ARG1: begin
            s_nxt.phase = disp_pkg::PH_IDLE;
            if (s_r.op == disp_pkg::OP_MODE) begin
              if (d[1:0] != disp_pkg::MODE_BAD) begin
                s_nxt.adr.mode = disp_pkg::addr_mode_e'(d[1:0]);
              end
            end else if (s_r.op == disp_pkg::OP_COL_WIN) begin
              s_nxt.adr.col_start = {1'b0, d[6:0]};
              s_nxt.phase = disp_pkg::PH_ARG2;
            end else if (s_r.op == disp_pkg::OP_PAGE_WIN) begin
              s_nxt.adr.page_start = d[2:0];
              s_nxt.phase = disp_pkg::PH_ARG2;
            end else if (s_r.op == disp_pkg::OP_CLK_SET) begin
              s_nxt.tim.clk_div = d[disp_pkg::NIB_LO +: 4];
              s_nxt.tim.osc = d[disp_pkg::NIB_HI +: 4];
            end else if (s_r.op == disp_pkg::OP_PRECHG) begin
              if (d[disp_pkg::NIB_LO +: 4] != 4'h0) begin
                s_nxt.tim.ph1 = d[disp_pkg::NIB_LO +: 4];
              end
              if (d[disp_pkg::NIB_HI +: 4] != 4'h0) begin
                s_nxt.tim.ph2 = d[disp_pkg::NIB_HI +: 4];
              end
            end else if (s_r.op == disp_pkg::OP_DESEL) begin
              s_nxt.tim.desel = d[disp_pkg::DESEL_LSB +: 4];
            end
          end
          disp_pkg::PH_ARG2: begin
            s_nxt.phase = disp_pkg::PH_IDLE;
            if (s_r.op == disp_pkg::OP_COL_WIN) begin
              s_nxt.adr.col_end = {1'b0, d[6:0]};
              s_nxt.adr.col = s_r.adr.col_start;
            end else begin
              s_nxt.adr.page_end = d[2:0];
              s_nxt.adr.page = s_r.adr.page_start;
            end
          end
          default: begin
            s_nxt.phase = disp_pkg::PH_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r <= '0;
      s_r.phase <= disp_pkg::PH_IDLE;
      s_r.tim.clk_div <= disp_pkg::RST_CLK_DIV;
      s_r.tim.osc <= disp_pkg::RST_OSC;
      s_r.tim.ph1 <= disp_pkg::RST_PH1;
      s_r.tim.ph2 <= disp_pkg::RST_PH2;
      s_r.tim.desel <= disp_pkg::RST_DESEL;
      s_r.adr.mode <= disp_pkg::MODE_PAGE;
      s_r.adr.col_start <= disp_pkg::RST_COL_START;
      s_r.adr.col_end <= disp_pkg::RST_COL_END;
      s_r.adr.page_start <= disp_pkg::RST_PAGE_START;
      s_r.adr.page_end <= disp_pkg::RST_PAGE_END;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ### bench/disp_cmd_top_checker.sv
// assertion checker on the display command interpreter ports
module disp_cmd_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_mode,
  input wire logic host_valid,
  input wire logic host_ready,
  input wire disp_pkg::host_req_s host_req,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [7:0] rd_data,
  input wire disp_pkg::timing_s timing,
  input wire disp_pkg::addr_s addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] win;
  // mode and both windows; a change here means a command, not a step
  assign win = {addr.mode, addr.col_start, addr.col_end, addr.page_start, addr.page_end};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  ph1_nonzero_a: assert property (timing.ph1 != 4'h0)
    else $error("phase one length is zero");
  ph2_nonzero_a: assert property (timing.ph2 != 4'h0)
    else $error("phase two length is zero");
  mode_valid_a: assert property (addr.mode != disp_pkg::MODE_BAD)
    else $error("addressing mode holds the invalid code");
  col_range_a: assert property (!addr.col_start[7] && !addr.col_end[7])
    else $error("column window above 127");
  rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read answer dropped or changed before taken");
  page_col_a: assert property (
    addr.mode == disp_pkg::MODE_PAGE && $stable(win) && $changed(addr.col)
    |-> $stable(addr.page)) else $error("page moved with column in page mode");
  horiz_wrap_a: assert property (
    addr.mode == disp_pkg::MODE_HORIZ && $stable(win) && $changed(addr.col)
    && $changed(addr.page) |-> addr.col == addr.col_start)
    else $error("horizontal page step without column wrap");
  vert_wrap_a: assert property (
    addr.mode == disp_pkg::MODE_VERT && $stable(win) && $changed(addr.col)
    && $changed(addr.page) |-> addr.page == addr.page_start)
    else $error("vertical column step without page wrap");
  vert_step_a: assert property (
    addr.mode == disp_pkg::MODE_VERT && $stable(win) && $changed(addr.page)
    && $stable(addr.col) |-> (addr.page == $past(addr.page) + 3'h1
    && $past(addr.page) != $past(addr.page_end)) || (addr.page == addr.page_start
    && $past(addr.page) == $past(addr.page_end))) else $error("vertical page step wrong");
endmodule

bind disp_cmd_top disp_cmd_checker u_disp_cmd_checker (.clk(clk), .rst_n(rst_n),
  .serial_mode(serial_mode), .host_valid(host_valid), .host_ready(host_ready),
  .host_req(host_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .timing(timing), .addr(addr));

// ### bench/host_model.sv
// host side model: byte requests out, read answers in
module host_model (
  input wire logic clk,
  input wire logic host_ready,
  output logic host_valid,
  output disp_pkg::host_req_s host_req,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall;
  logic [7:0] rq[$];
  initial begin
    host_valid = 1'b0;
    host_req = '0;
    stall = 1'b0;
  end
  // stall lets the bench answer slowly and back the fifo up
  assign rd_ready = !stall;
  // answer taken at the edge where valid and ready meet, as the design sees it
  always @(posedge clk) begin
    if (rd_valid && rd_ready) begin
      rq.push_back(rd_data);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic dc, input logic rnw, input logic [7:0] d, output logic ok);
    int n;
    n = 0;
    @(negedge clk);
    host_req = '{dc: dc, rnw: rnw, data: d};
    host_valid = 1'b1;
    while (!host_ready && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    host_valid = 1'b0;
    // released byte lines must not look like the old byte
    host_req.data = ~d;
    ok = (n < 200);
  endtask
endmodule

// ### bench/display_ram_access_and_timing_setup_tb.sv
// self-checking bench for the display command interpreter
module display_ram_access_and_timing_setup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic serial_mode;
  logic host_valid;
  logic host_ready;
  disp_pkg::host_req_s host_req;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;
  disp_pkg::timing_s timing;
  disp_pkg::addr_s addr;
  int n_mismatch;
  int num_checks;
  logic [7:0] got;
  logic [36:0] rows [8];
  logic [10:0] walk [8];

  always #5 clk = ~clk;

  disp_cmd_top u_disp_cmd_top (.clk(clk), .rst_n(rst_n), .serial_mode(serial_mode),
    .host_valid(host_valid), .host_ready(host_ready), .host_req(host_req),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .timing(timing),
    .addr(addr));
  host_model u_host_model (.clk(clk), .host_ready(host_ready), .host_valid(host_valid),
    .host_req(host_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rst();
    chk(timing, {disp_pkg::RST_CLK_DIV, disp_pkg::RST_OSC, disp_pkg::RST_PH1,
      disp_pkg::RST_PH2, disp_pkg::RST_DESEL, 1'b0});
    chk(addr, {disp_pkg::MODE_PAGE, disp_pkg::RST_COL_START, disp_pkg::RST_COL_END,
      disp_pkg::RST_PAGE_START, disp_pkg::RST_PAGE_END, 11'h000});
  endtask
  task automatic tx(input logic dc, input logic rnw, input logic [7:0] d);
    logic ok;
    u_host_model.send(dc, rnw, d, ok);
    if (!ok) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] d);
    tx(1'b0, 1'b0, d);
  endtask
  // answer lands two cycles after the take; four leaves margin
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  task automatic rd(input logic dc, output logic [7:0] v);
    int n;
    n = 0;
    tx(dc, 1'b1, 8'h00);
    while (u_host_model.rq.size() == 0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) begin
      n_mismatch++;
      conclude();
    end
    v = u_host_model.rq.pop_front();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    serial_mode = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    // command, parameter, expected {div, osc, ph1, ph2, desel, on}
    rows = '{{16'hD5A3, 21'h3A22D << 1}, {16'hD5F0, 21'h0F22D << 1},
      {16'hD9F1, 21'h0F1FD << 1}, {16'hD930, 21'h0F13D << 1}, {16'hD900, 21'h0F13D << 1},
      {16'hDB00, 21'h0F130 << 1}, {16'hDB3C, 21'h0F13F << 1}, {16'hDB34, 21'h0F13D << 1}};
    walk = '{{8'h61, 3'h1}, {8'h60, 3'h2}, {8'h61, 3'h2}, {8'h60, 3'h1},
      {8'h60, 3'h2}, {8'h61, 3'h1}, {8'h61, 3'h2}, {8'h60, 3'h1}};
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_rst();
    rd(1'b0, got);
    chk(got, 8'h40);
    for (int i = 0; i < 8; i++) begin
      cmd(rows[i][36:29]);
      cmd(rows[i][28:21]);
      settle();
      chk(timing, rows[i][20:0]);
    end
    cmd(8'hAF);
    settle();
    rd(1'b0, got);
    chk(got, 8'h00);
    cmd(8'hAE);
    cmd(8'hB2);
    cmd(8'h03);
    cmd(8'h10);
    settle();
    chk({addr.col, addr.page}, 11'h01A);
    tx(1'b1, 1'b0, 8'h11);
    settle();
    chk({addr.col, addr.page}, 11'h022);
    cmd(8'h0F);
    cmd(8'h17);
    tx(1'b1, 1'b0, 8'h12);
    settle();
    chk({addr.col, addr.page}, 11'h002);
    cmd(8'h20);
    cmd(8'h00);
    cmd(8'h21);
    cmd(8'h60);
    cmd(8'h61);
    cmd(8'h22);
    cmd(8'h01);
    cmd(8'h02);
    settle();
    chk({addr.col, addr.page}, 11'h301);
    for (int j = 0; j < 8; j++) begin
      if (j == 4) begin
        cmd(8'h20);
        cmd(8'h01);
      end
      tx(1'b1, 1'b0, 8'h20 + 8'(j));
      settle();
      chk({addr.col, addr.page}, walk[j]);
    end
    cmd(8'h20);
    cmd(8'h03);
    settle();
    chk(addr.mode, disp_pkg::MODE_VERT);
    cmd(8'h20);
    cmd(8'h02);
    cmd(8'hB0);
    cmd(8'h0A);
    cmd(8'h10);
    tx(1'b1, 1'b0, 8'h55);
    tx(1'b1, 1'b0, 8'hAA);
    cmd(8'h0A);
    cmd(8'h10);
    rd(1'b1, got);
    settle();
    chk(addr.col, 8'h0B);
    rd(1'b1, got);
    chk(got, 8'h55);
    rd(1'b0, got);
    settle();
    chk({got, addr.col}, 16'h400C);
    // parameters of commands kept elsewhere must not decode as commands
    cmd(8'h81);
    cmd(8'hB5);
    cmd(8'hA8);
    cmd(8'h1F);
    settle();
    chk({addr.col, addr.page}, 11'h060);
    serial_mode = 1'b1;
    cmd(8'h0A);
    cmd(8'h10);
    tx(1'b1, 1'b1, 8'h77);
    settle();
    chk({u_host_model.rq.size() == 0, addr.col}, 9'h10B);
    serial_mode = 1'b0;
    cmd(8'h0A);
    cmd(8'h10);
    rd(1'b1, got);
    rd(1'b1, got);
    chk(got, 8'h77);
    // unanswered read parks the interpreter, so the fifo fills
    u_host_model.stall = 1'b1;
    tx(1'b0, 1'b1, 8'h00);
    repeat (16) cmd(8'hE3);
    settle();
    chk(host_ready, 1'b0);
    u_host_model.stall = 1'b0;
    rd(1'b0, got);
    chk(got, 8'h40);
    for (int k = 0; k < 60 && !host_ready; k++) @(negedge clk);
    chk(host_ready, 1'b1);
    // reset in mid-run: drain the queued status read first, then start clean
    repeat (40) @(negedge clk);
    u_host_model.rq.delete();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(host_ready, 1'b0);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk_rst();
    rd(1'b0, got);
    chk(got, 8'h40);
    conclude();
  end
endmodule
